// ---- tfs_regs.svh ----
`ifndef TFS_REGS_SVH
`define TFS_REGS_SVH
// register byte offsets
`define TFS_CMD_OFS   12'h000
`define TFS_STAT_OFS  12'h004
`define TFS_WC_OFS    12'h008
`define TFS_CA_OFS    12'h00C
// command register fields
`define TFS_CMD_UNIT  0
`define TFS_CMD_DIR   3
`define TFS_CMD_GO    4
`define TFS_CMD_MODE  5
`define TFS_CMD_FN    6
`define TFS_CMD_IEN   9
// status register fields
`define TFS_ERR_END   0
`define TFS_ERR_MARK  1
`define TFS_ERR_SEL   2
`define TFS_ERR_PAR   3
`define TFS_ERR_TIM   4
`define TFS_ST_EFLAG  16
`define TFS_ST_DONE   17
`define TFS_ST_OVF    18
// reset and seed values
`define TFS_WORD_RST  18'h00000
`define TFS_SUM_SEED  6'h3F
`endif

// ---- tfs_pkg.sv ----
package tfs_pkg;
	// function field codes, in encoding order 0..7
	typedef enum logic [2:0] {
		FN_MOVE, FN_SEARCH, FN_READ, FN_RAW_READ,
		FN_BLK_WRITE, FN_RAW_WRITE, FN_TMARK, FN_UNUSED
	} fn_e;
endpackage : tfs_pkg

// ---- tape_function_sequencer.sv ----
`timescale 1ns/10ps
`include "tfs_regs.svh"
// Operation
// - raw read ignores marks except errors, end
// - raw read normal: done per word
// - raw read: after overflow stop transfers, keep moving
// - uncleared done at next word: timing error
// - raw read continuous: done only at overflow
// - block write normal: done per block, rearm
// - partial block: zero fill, record checksum
// - block write continuous: done at overflow block
// - raw write: overflow word written last
// - timing write: mark bits, switch must match
// - timing write normal: done per word, error
// - timing write continuous: zeros after overflow
// - interrupt gated by enable bit only
// - errors set bit, flag; skip ORs
// - non-parity errors stop transport, no done
// - normal parity error: keep go, with done
// - continuous parity error at block end
// - search stores block number, no increment
// - word request per word, address preincremented
// - equivalence checksum written and verified
// - only selected transport is sensed, stopped
// - function decode, code 7 select error
module tape_function_sequencer (
	input  wire logic        mclk,          // system clock
	input  wire logic        resetn,        // async reset
	input  wire logic        psel,          // apb select
	input  wire logic        penable,       // apb enable
	input  wire logic        pwrite,        // apb direction
	input  wire logic [11:0] paddr,         // apb address
	input  wire logic [31:0] pwdata,        // apb write data
	output logic      [31:0] prdata,        // apb read data
	output logic             pready,        // apb ready
	output logic             pslverr,       // apb error
	output logic             brk_req,       // word request flag
	output logic             brk_to_mem,    // break writes memory
	output logic      [17:0] brk_addr,      // break address
	output logic      [17:0] brk_wdata,     // data toward memory
	input  wire logic        brk_ack,       // break granted
	input  wire logic [17:0] brk_rdata,     // data from memory
	input  wire logic [17:0] tape_word,     // assembled tape word
	input  wire logic        tape_tick,     // word time
	input  wire logic        tape_zone,     // data portion of block
	input  wire logic        tape_blk_mark, // block number seen
	input  wire logic        tape_blk_end,  // checksum word seen
	input  wire logic        tape_mark_err, // mark_track_error
	input  wire logic        tape_end_zone, // tape_end_zone
	input  wire logic        timing_mark_write_setting_switch,   // timing_mark_write_setting
	output logic      [7:0]  tape_run,      // motion per transport
	output logic      [2:0]  tape_unit,     // selected transport
	output logic             tape_dir,      // direction
	output logic             wr_enable,     // data writers on
	output logic             tm_enable,     // timing/mark writers on
	output logic      [17:0] wr_word,       // word to record
	output logic             wr_stb,        // record strobe
	output logic      [5:0]  mark_bits,     // mark track value
	output logic             irq,           // interrupt request
	output logic             error_skip_test, // skip on any error
	output logic             done_flag      // done_flag
);
	localparam int TK = 18;
	localparam int ZN = 19;
	localparam int BM = 20;
	localparam int BE = 21;
	localparam int ME = 22;
	localparam int EZ = 23;
	localparam int SW = 24;

	typedef enum logic [1:0] {PH_IDLE, PH_DATA, PH_SUM} phase_e;

	typedef struct packed {
		logic [24:0]   s1;
		logic [24:0]   s2;
		logic [24:0]   s3;
		logic [2:0]    unit;
		logic          dir;
		logic          go;
		logic          cm;
		tfs_pkg::fn_e  fn;
		logic          ien;
		logic [7:0]    run;
		logic [17:0]   wc;
		logic [17:0]   ca;
		logic          ovf;
		logic          blk_ovf;
		logic          done;
		logic [4:0]    err;
		logic          eflag;
		logic          req;
		logic          to_mem;
		logic [17:0]   baddr;
		logic [17:0]   bdata;
		logic [17:0]   wword;
		logic          wstb;
		logic          wen;
		logic          tmen;
		logic [5:0]    mark;
		logic [5:0]    sum;
		phase_e        phase;
		logic          irq;
		logic          eskip;
		logic          pready;
		logic [31:0]   prdata;
		logic          pslverr;
	} state_s;

	state_s q;
	state_s n;

	function automatic logic [17:0] inc18(input logic [17:0] v);
		inc18 = v + 18'h00001;
	endfunction : inc18

	// equivalence of the three 6-bit slices into the running sum
	function automatic logic [5:0] fold(input logic [5:0] s,
			input logic [17:0] w);
		fold = ~(s ^ w[5:0] ^ w[11:6] ^ w[17:12]);
	endfunction : fold

	logic tick;
	logic bmark;
	logic bend;
	logic merr;
	logic xfer;
	logic xfer_wr;
	logic wrap;
	logic done_set;
	logic [4:0] err_set;
	logic wr_do;
	logic [17:0] rdw;

	always_comb begin
		n = q;
		err_set = 5'h00;
		done_set = 1'b0;
		xfer = 1'b0;
		xfer_wr = 1'b0;
		wrap = 1'b0;
		n.wstb = 1'b0;
		// two-stage sync, third stage only for edge detection
		n.s1 = {timing_mark_write_setting_switch, tape_end_zone, tape_mark_err, tape_blk_end,
			tape_blk_mark, tape_zone, tape_tick, tape_word};
		n.s2 = q.s1;
		n.s3 = q.s2;
		rdw = q.s2[17:0];
		tick = q.s2[TK] & ~q.s3[TK];
		bmark = q.s2[BM] & ~q.s3[BM];
		bend = q.s2[BE] & ~q.s3[BE];
		merr = q.s2[ME] & ~q.s3[ME];
		// apb: one wait state, then the access completes
		n.pready = psel & penable & ~q.pready;
		wr_do = psel & penable & q.pready & pwrite;
		if (n.pready) begin
			n.pslverr = 1'b0;
			if (paddr == `TFS_CMD_OFS) begin
				n.prdata = {22'h000000, q.ien, 3'(q.fn), q.cm, q.go,
					q.dir, q.unit};
			end else if (paddr == `TFS_STAT_OFS) begin
				n.prdata = {13'h0000, q.ovf, q.done, q.eflag, 11'h000,
					q.err};
			end else if (paddr == `TFS_WC_OFS) begin
				n.prdata = {14'h0000, q.wc};
			end else if (paddr == `TFS_CA_OFS) begin
				n.prdata = {14'h0000, q.ca};
			end else begin
				n.prdata = 32'h00000000;
				n.pslverr = 1'b1;
			end
		end
		// register writes; placed first so that later events win
		if (wr_do) begin
			if (paddr == `TFS_CMD_OFS) begin
				n.unit = pwdata[`TFS_CMD_UNIT +: 3];
				n.dir = pwdata[`TFS_CMD_DIR];
				n.go = pwdata[`TFS_CMD_GO];
				n.cm = pwdata[`TFS_CMD_MODE];
				n.fn = tfs_pkg::fn_e'(pwdata[`TFS_CMD_FN +: 3]);
				n.ien = pwdata[`TFS_CMD_IEN];
				// other transports keep whatever motion they had
				n.run[pwdata[`TFS_CMD_UNIT +: 3]] = pwdata[`TFS_CMD_GO];
				n.ovf = 1'b0;
				n.phase = PH_IDLE;
				if (n.fn == tfs_pkg::FN_UNUSED)
					err_set[`TFS_ERR_SEL] = 1'b1;
				if (q.s2[SW] != (n.fn == tfs_pkg::FN_TMARK))
					err_set[`TFS_ERR_SEL] = 1'b1;
			end else if (paddr == `TFS_STAT_OFS) begin
				n.err = q.err & ~pwdata[4:0];
				n.eflag = q.eflag & ~pwdata[`TFS_ST_EFLAG];
				n.done = q.done & ~pwdata[`TFS_ST_DONE];
			end else if (paddr == `TFS_WC_OFS) begin
				n.wc = pwdata[17:0];
			end else if (paddr == `TFS_CA_OFS) begin
				n.ca = pwdata[17:0];
			end
		end
		// data break answered: memory word goes to the writers
		if (q.req && brk_ack) begin
			n.req = 1'b0;
			if (!q.to_mem) begin
				n.wword = brk_rdata;
				n.wstb = q.wen | q.tmen;
				n.mark = {brk_rdata[15], brk_rdata[12], brk_rdata[9],
					brk_rdata[6], brk_rdata[3], brk_rdata[0]};
				if (q.fn == tfs_pkg::FN_BLK_WRITE)
					n.sum = fold(q.sum, brk_rdata);
			end
		end
		if (q.go) begin
			// only the selected unit's sensors reach these pins
			if (q.s2[EZ]) err_set[`TFS_ERR_END] = 1'b1;
			if (merr) err_set[`TFS_ERR_MARK] = 1'b1;
			// previous break still pending at the next word
			if (tick && q.req) err_set[`TFS_ERR_TIM] = 1'b1;
			case (q.fn)
				tfs_pkg::FN_RAW_READ, tfs_pkg::FN_RAW_WRITE,
				tfs_pkg::FN_TMARK: begin
					if (tick) begin
						if (q.fn == tfs_pkg::FN_RAW_WRITE && q.ovf)
							n.wen = 1'b0;
						if (!q.ovf) begin
							xfer = 1'b1;
							xfer_wr = (q.fn == tfs_pkg::FN_RAW_READ);
							if (q.fn == tfs_pkg::FN_RAW_WRITE) n.wen = 1'b1;
							if (q.fn == tfs_pkg::FN_TMARK)
								n.tmen = q.s2[SW];
							if (!q.cm) begin
								if (q.done)
									err_set[`TFS_ERR_TIM] = 1'b1;
								else
									done_set = 1'b1;
							end
						end else if (q.fn == tfs_pkg::FN_TMARK) begin
							if (q.cm) begin
								n.wword = `TFS_WORD_RST;
								n.mark = 6'h00;
								n.wstb = q.tmen;
							end else if (q.done) begin
								err_set[`TFS_ERR_TIM] = 1'b1;
							end
						end
					end
				end
				tfs_pkg::FN_READ, tfs_pkg::FN_BLK_WRITE: begin
					if (bmark) begin
						n.sum = `TFS_SUM_SEED;
						n.blk_ovf = 1'b0;
						n.phase = PH_DATA;
						if (q.fn == tfs_pkg::FN_BLK_WRITE)
							n.wen = ~q.ovf & (q.cm | ~q.done);
					end
					if (tick && q.s2[ZN] && q.phase == PH_DATA) begin
						if (q.fn == tfs_pkg::FN_READ)
							n.sum = fold(q.sum, rdw);
						if (!q.ovf) begin
							xfer = 1'b1;
							xfer_wr = (q.fn == tfs_pkg::FN_READ);
						end else if (q.fn == tfs_pkg::FN_BLK_WRITE) begin
							n.wword = `TFS_WORD_RST;
							n.wstb = q.wen;
							n.sum = fold(q.sum, `TFS_WORD_RST);
						end
					end
					if (bend && q.phase == PH_DATA) begin
						n.phase = PH_SUM;
						if (q.fn == tfs_pkg::FN_BLK_WRITE) begin
							n.wword = {12'h000, q.sum};
							n.wstb = q.wen;
						end else if (fold(q.sum, rdw) != 6'h3F) begin
							err_set[`TFS_ERR_PAR] = 1'b1;
						end
						if (!q.cm || q.blk_ovf)
							done_set = 1'b1;
					end
					if (q.phase == PH_SUM && q.ovf)
						n.wen = 1'b0;
				end
				tfs_pkg::FN_SEARCH: begin
					if (bmark) begin
						// no block number is stored once the count wrapped
						xfer = !q.ovf;
						xfer_wr = 1'b1;
						if (!q.cm) done_set = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		// word request; the address is bumped before each transfer except a search
		if (xfer) begin
			n.wc = inc18(q.wc);
			wrap = (n.wc == `TFS_WORD_RST);
			n.req = 1'b1;
			n.to_mem = xfer_wr;
			n.bdata = rdw;
			if (q.fn == tfs_pkg::FN_SEARCH) begin
				n.baddr = q.ca;
			end else begin
				n.ca = inc18(q.ca);
				n.baddr = n.ca;
			end
			if (wrap) begin
				n.ovf = 1'b1;
				n.blk_ovf = 1'b1;
				if (q.cm && q.fn != tfs_pkg::FN_READ &&
					q.fn != tfs_pkg::FN_BLK_WRITE)
					done_set = 1'b1;
			end
		end
		// errors: flag and bit; all but parity stop the unit
		if (err_set != 5'h00) n.eflag = 1'b1;
		n.err = n.err | err_set;
		if ((err_set & ~(5'h01 << `TFS_ERR_PAR)) != 5'h00) begin
			n.go = 1'b0;
			n.run[q.unit] = 1'b0;
			n.req = 1'b0;
			n.wen = 1'b0;
			n.tmen = 1'b0;
			done_set = 1'b0;
		end
		if (done_set) n.done = 1'b1;
		if (!n.go) begin
			n.wen = 1'b0;
			n.tmen = 1'b0;
		end
		// the enable gates the request only, never the flags
		n.irq = n.ien & (n.done | n.eflag);
		n.eskip = |n.err;
	end

	// single state register
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
			q.fn <= tfs_pkg::FN_MOVE;
			q.phase <= PH_IDLE;
			q.sum <= `TFS_SUM_SEED;
		end else begin
			q <= n;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign brk_req = q.req;
	assign brk_to_mem = q.to_mem;
	assign brk_addr = q.baddr;
	assign brk_wdata = q.bdata;
	assign tape_run = q.run;
	assign tape_unit = q.unit;
	assign tape_dir = q.dir;
	assign wr_enable = q.wen;
	assign tm_enable = q.tmen;
	assign wr_word = q.wword;
	assign wr_stb = q.wstb;
	assign mark_bits = q.mark;
	assign irq = q.irq;
	assign error_skip_test = q.eskip;
	assign done_flag = q.done;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	chk_irq_gate: assert property (q.irq |-> q.ien)
		else $error("interrupt without enable");
	chk_skip_or: assert property (q.eskip == (q.err != 5'h00))
		else $error("skip differs from error or");
	chk_err_stops: assert property (
		$rose(q.err[`TFS_ERR_TIM] | q.err[`TFS_ERR_MARK]) |-> !q.go)
		else $error("transport not stopped on error");
	chk_par_done: assert property (
		$rose(q.err[`TFS_ERR_PAR]) && !$past(q.cm) |-> q.done && q.go)
		else $error("normal parity error without done");
	chk_cm_done_ovf: assert property (
		$rose(q.done) && q.cm && q.fn == tfs_pkg::FN_RAW_READ |-> q.ovf)
		else $error("continuous done before overflow");
	chk_no_xfer_ovf: assert property (
		$rose(q.req) |-> !$past(q.ovf) || $past(wr_do))
		else $error("transfer after overflow");
	chk_sel_code: assert property (
		wr_do && paddr == `TFS_CMD_OFS && pwdata[8:6] == 3'h7
		|=> q.err[`TFS_ERR_SEL] && !q.go)
		else $error("unused function not rejected");
	chk_search_addr: assert property (
		$rose(q.req) && q.fn == tfs_pkg::FN_SEARCH && !$past(wr_do)
		|-> q.baddr == q.ca && q.ca == $past(q.ca))
		else $error("search moved the address");
	chk_rr_done: assert property (
		q.go && !q.cm && q.fn == tfs_pkg::FN_RAW_READ && tick && !q.ovf
		&& !q.done && !wr_do |=> q.done || q.eflag)
		else $error("raw read word without done");
	cov_rr_done: cover property (
		q.fn == tfs_pkg::FN_RAW_READ && $rose(q.done));
	cov_par_err: cover property ($rose(q.err[`TFS_ERR_PAR]));
	cov_zero_fill: cover property (
		q.wstb && q.ovf && q.fn == tfs_pkg::FN_BLK_WRITE);
endmodule : tape_function_sequencer

// ---- chan_model.sv ----
`timescale 1ns/10ps
// data channel side: grants each word request after a set stall
module chan_model (
	input  wire logic        mclk,       // system clock
	input  wire logic        resetn,     // async reset
	input  wire logic [3:0]  stall,      // cycles before grant
	input  wire logic        brk_req,    // word request flag
	input  wire logic        brk_to_mem, // 1 = write memory
	input  wire logic [17:0] brk_addr,   // break address
	input  wire logic [17:0] brk_wdata,  // word toward memory
	output logic             brk_ack,    // one-cycle grant
	output logic      [17:0] brk_rdata   // word from memory
);
	logic [17:0] mem [256]; // small memory window
	int          cnt;
	// data line toggles outside grants so stale words never look valid
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			brk_ack <= 1'b0;
			brk_rdata <= 18'h15555;
			cnt <= 0;
		end else if (brk_ack) begin
			brk_ack <= 1'b0;
			brk_rdata <= ~brk_rdata;
			cnt <= 0;
			if (brk_to_mem) mem[brk_addr[7:0]] <= brk_wdata;
		end else if (brk_req && cnt >= stall) begin
			brk_ack <= 1'b1;
			brk_rdata <= mem[brk_addr[7:0]];
		end else begin
			cnt <= brk_req ? cnt + 1 : 0;
			brk_rdata <= ~brk_rdata;
		end
	end
endmodule : chan_model

// ---- testbench.sv ----
`timescale 1ns/10ps
`include "tfs_regs.svh"
module testbench;
	localparam logic [11:0] CM_A = `TFS_CMD_OFS;
	localparam logic [11:0] ST_A = `TFS_STAT_OFS;
	localparam logic [11:0] WC_A = `TFS_WC_OFS;
	localparam logic [11:0] CA_A = `TFS_CA_OFS;
	logic        mclk, resetn, psel, penable, pwrite, pready, pslverr;
	logic        brk_req, brk_to_mem, brk_ack, tape_tick, tape_zone;
	logic        tape_blk_mark, tape_blk_end, tape_mark_err, tape_end_zone;
	logic        timing_mark_write_setting_switch, tm_enable, wr_enable, wr_stb, tape_dir, irq;
	logic        error_skip_test, done_flag, b_mem, b_seen, rerr;
	logic [2:0]  tape_unit;
	logic [3:0]  stall;
	logic [5:0]  mark_bits;
	logic [7:0]  tape_run;
	logic [11:0] paddr;
	logic [17:0] brk_addr, brk_wdata, brk_rdata, tape_word, wr_word, b_addr;
	logic [31:0] pwdata, prdata, rdv;
	int          failures, n_tests, cyc, n_stb, n_brk;

	tape_function_sequencer dut (.*);
	chan_model mdl (.*);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// hang guard, record strobes and answered word requests
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (wr_stb === 1'b1) n_stb <= n_stb + 1;
		// a break counts at the edge where the grant is taken
		if (brk_req === 1'b1 && brk_ack === 1'b1) begin
			n_brk <= n_brk + 1;
			b_addr <= brk_addr;
			b_mem <= brk_to_mem;
		end
		if (cyc == 60000) begin
			failures++;
			stop_test();
		end
	end

	task stop_test;
		$display("failures=%0d n_tests=%0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one apb transfer; held until pready is seen high at a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// no local limit; if pready never rises only the bench timeout ends this wait
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1);
		rdv = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", 32'h2, n);
		@(negedge mclk);
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd

	task start(input logic [2:0] fn, input logic md, input logic [17:0] ca);
		wr(ST_A, 32'h0003001F);
		wr(WC_A, (fn == 3'h5) ? 32'h3FFFF : 32'h3FFFE);
		wr(CA_A, {14'h0, ca});
		wr(CM_A, {22'h0, 1'b1, fn, md, 5'h12}); // go, unit 2
		@(negedge mclk);
	endtask : start

	// tape word or block mark, held three cycles past the synchronisers
	task ev(input logic mk, input logic [17:0] w);
		int n;
		int b0;
		n = 0;
		b0 = n_brk;
		@(posedge mclk);
		tape_word <= w;
		repeat (2) @(posedge mclk);
		tape_tick <= ~mk;
		tape_blk_mark <= mk;
		repeat (3) @(posedge mclk);
		tape_tick <= 1'b0;
		tape_blk_mark <= 1'b0;
		repeat (3) @(posedge mclk);
		while (brk_req !== 1'b0 && n < 30) begin
			@(posedge mclk);
			n++;
		end
		repeat (2) @(negedge mclk);
		b_seen = (n_brk != b0);
	endtask : ev

	// block end with its checksum word on the data lines
	task eob(input logic [17:0] w);
		@(posedge mclk);
		tape_word <= w;
		repeat (2) @(posedge mclk);
		tape_blk_end <= 1'b1;
		repeat (3) @(posedge mclk);
		tape_blk_end <= 1'b0;
		repeat (4) @(posedge mclk);
		@(negedge mclk);
	endtask : eob

	task t_reset;
		chk("run0", 32'h0, {tape_run, irq, done_flag});
		rd(CM_A);
		chk("cmd0", 32'h0, rdv);
		rd(ST_A);
		chk("st0", 32'h0, rdv);
		rd(12'h010);
		chk("unmap", 32'h1, {31'h0, rerr});
		chk("unmapd", 32'h0, rdv);
		wr(WC_A, 32'hFFFFFFFF);
		rd(WC_A);
		chk("wc", 32'h3FFFF, rdv);
		wr(CM_A, 32'h00000008);
		chk("dir", 32'h1, tape_dir);
	endtask : t_reset

	task t_raw_read;
		stall = 4'h5;
		start(3'h3, 1'b0, 18'h10);
		chk("runsel", 32'h22, {tape_run, tape_unit});
		ev(1'b0, 18'h2A5C3);
		chk("brk", 32'h311, {b_seen, b_mem, b_addr[7:0]});
		chk("mem", 32'h2A5C3, mdl.mem[8'h11]);
		chk("done", 32'h3, {done_flag, irq});
		wr(ST_A, 32'h00020000);
		ev(1'b0, 18'h0F0F0);
		chk("mem2", 32'h0F0F0, mdl.mem[8'h12]);
		rd(ST_A);
		chk("ovf", 32'h1, rdv[18]);
		rd(CA_A);
		chk("ca", 32'h12, rdv);
		wr(ST_A, 32'h00020000);
		ev(1'b0, 18'h33333);
		chk("after", 32'h4, {b_seen, tape_run});
	endtask : t_raw_read

	task t_cont;
		stall = 4'h0;
		start(3'h3, 1'b1, 18'h40);
		wr(CM_A, 32'h000000F2); // interrupt enable off
		ev(1'b0, 18'h11111);
		chk("cdone", 32'h0, done_flag);
		ev(1'b0, 18'h22222);
		chk("cdone2", 32'h2, {done_flag, irq});
		chk("cmem", 32'h22222, mdl.mem[8'h42]);
		ev(1'b0, 18'h00003);
		chk("cstop", 32'h4, {b_seen, tape_run});
	endtask : t_cont

	task t_timing;
		start(3'h3, 1'b0, 18'h50);
		ev(1'b0, 18'h00001);
		ev(1'b0, 18'h00002);
		rd(ST_A);
		chk("tim", 32'h30, {rdv[16], rdv[4:0]});
		chk("stop", 32'h3, {tape_run, error_skip_test, irq});
	endtask : t_timing

	task t_select;
		logic [2:0] fn [3];
		logic       sw [3];
		fn = '{3'h7, 3'h6, 3'h4};
		sw = '{1'b0, 1'b0, 1'b1};
		for (int i = 0; i < 3; i++) begin
			timing_mark_write_setting_switch <= sw[i];
			start(fn[i], 1'b0, 18'h0);
			rd(ST_A);
			chk("sel", 32'h24, {rdv[17:16], rdv[4:0]});
			chk("selrun", 32'h1, {tape_run, error_skip_test});
		end
	endtask : t_select

	task t_tmark;
		stall = 4'h6;
		timing_mark_write_setting_switch <= 1'b1;
		mdl.mem[8'h61] = 18'h01047;
		start(3'h6, 1'b0, 18'h60);
		ev(1'b0, 18'h00000);
		chk("tm", 32'h1, tm_enable);
		chk("tmw", 32'h3, {b_mem, b_seen, done_flag});
		chk("tmword", 32'h01047, wr_word);
		chk("mark", 32'h15, mark_bits);
		timing_mark_write_setting_switch <= 1'b0;
	endtask : t_tmark

	task t_raw_write;
		int s0;
		mdl.mem[8'h21] = 18'h1B2C4;
		start(3'h5, 1'b0, 18'h20);
		s0 = n_stb;
		ev(1'b0, 18'h00000);
		chk("rwword", 32'h1B2C4, wr_word);
		chk("rwstb", 32'h1, n_stb - s0);
		ev(1'b0, 18'h00000);
		chk("rwoff", 32'h4, {wr_enable, tape_run});
		chk("rwlast", 32'h1, n_stb - s0);
		repeat (9000) @(posedge mclk);
	endtask : t_raw_write

	task t_search;
		stall = 4'h2;
		start(3'h1, 1'b0, 18'h30);
		ev(1'b1, 18'h00123);
		chk("sadr", 32'h130, {b_mem, b_addr[7:0]});
		chk("smem", 32'h00123, mdl.mem[8'h30]);
		chk("sdone", 32'h1, done_flag);
		rd(CA_A);
		chk("sca", 32'h30, rdv);
	endtask : t_search

	// one word, then zero fill and checksum 3E for the block
	task t_blk_write;
		int s0;
		stall = 4'h0;
		mdl.mem[8'h71] = 18'h01041;
		start(3'h4, 1'b0, 18'h70);
		wr(WC_A, 32'h3FFFF); // overflow on the first word
		tape_zone <= 1'b1;
		ev(1'b1, 18'h00000);
		s0 = n_stb;
		ev(1'b0, 18'h00000);
		chk("bwword", 32'h01041, wr_word);
		ev(1'b0, 18'h00000);
		chk("bwzero", 32'h0, wr_word);
		eob(18'h00000);
		chk("bwsum", 32'h3E, wr_word);
		chk("bwstb", 32'h3, n_stb - s0);
		chk("bwend", 32'h204, {done_flag, wr_enable, tape_run});
		tape_zone <= 1'b0;
	endtask : t_blk_write

	// a good checksum block, then a bad one in normal mode
	task t_blk_read;
		logic [31:0] st [2];
		st = '{32'h40, 32'h68};
		start(3'h2, 1'b0, 18'h78);
		tape_zone <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			ev(1'b1, 18'h00000);
			ev(1'b0, 18'h01041);
			eob(i ? 18'h00000 : 18'h00001);
			rd(ST_A);
			chk("par", st[i], {rdv[17:16], rdv[4:0]});
			wr(ST_A, 32'h00020000);
		end
		chk("pmem", 32'h01041, mdl.mem[8'h7A]);
		chk("prun", 32'h9, {tape_run, irq});
		tape_zone <= 1'b0;
	endtask : t_blk_read

	// mark error sets its status bit; end zone stops only the selected unit
	task t_sense;
		start(3'h0, 1'b0, 18'h0);
		tape_mark_err <= 1'b1;
		repeat (6) @(posedge mclk);
		tape_mark_err <= 1'b0;
		rd(ST_A);
		chk("mkerr", 32'h22, {rdv[17:16], rdv[4:0]});
		start(3'h0, 1'b0, 18'h0);
		wr(CM_A, 32'h0000001B); // unit 3 runs, unit 2 left moving
		tape_end_zone <= 1'b1;
		repeat (6) @(posedge mclk);
		tape_end_zone <= 1'b0;
		rd(ST_A);
		chk("ezone", 32'h21, {rdv[17:16], rdv[4:0]});
		chk("ezrun", 32'h04, tape_run);
	endtask : t_sense

	initial begin
		{resetn, psel, penable, pwrite, tape_tick, tape_zone} = '0;
		{tape_blk_mark, tape_blk_end, tape_mark_err, tape_end_zone} = '0;
		{timing_mark_write_setting_switch, paddr, pwdata, tape_word, stall} = '0;
		{failures, n_tests, cyc, n_stb, n_brk} = '0;
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		@(negedge mclk);
		t_reset();
		t_raw_read();
		t_cont();
		t_timing();
		t_select();
		t_tmark();
		t_raw_write();
		t_search();
		t_blk_write();
		t_blk_read();
		t_sense();
		stop_test();
	end
endmodule : testbench
